// ==== hdl/wrc_pkg.sv ====
// Purpose: Constants and types for the watchdog and reset combiner.
// Assumes: 200 MHz clock, synchronous inputs.
// Notes:   Long counts are module parameters so simulation can shorten them.
package wrc_pkg;

  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam longint unsigned HOLD_TIME_MS = 200;
  localparam longint unsigned WDT_TIME_MS  = 1600;
  localparam longint unsigned EXT_MIN_NS   = 500;
  localparam longint unsigned SVC_MIN_NS   = 100;

  // Least times round up, longest round down
  localparam longint unsigned HOLD_CYCLES =
    (HOLD_TIME_MS * 64'd1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam longint unsigned WDT_CYCLES  =
    (WDT_TIME_MS * 64'd1000000000) / CLK_PERIOD_PS;
  localparam int unsigned EXT_CYCLES =
    32'((EXT_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned SVC_CYCLES =
    32'((SVC_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  localparam int unsigned CNT_W = 32;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 32'h0000_0001;

  typedef enum logic [0:0] {
    WRC_RUN,
    WRC_HOLD
  } wrc_state_t;

  typedef struct packed {
    logic power_supervisor;
    logic ext_reset;
    logic watchdog_timer;
  } wrc_src_t;

endpackage : wrc_pkg

// ==== hdl/wrc_top.sv ====
// Purpose: Watchdog timer and reset combiner driving the processor reset.
// Assumes: Inputs synchronous to clock; external and service pulses meet widths.
// Notes:   Reset output is a registered active-low level.
`timescale 1ns/1ps
module wrc_top
  import wrc_pkg::*;
#(
  parameter logic [CNT_W-1:0] HOLD_CNT = CNT_W'(HOLD_CYCLES),
  parameter logic [CNT_W-1:0] WDT_CNT  = CNT_W'(WDT_CYCLES)
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic clk_en,
  // Reset sources
  input  wire logic power_supervisor_n,
  input  wire logic ext_reset_n,
  // Watchdog service and disconnect strap
  input  wire logic wdt_service,
  input  wire logic wdt_disconnect,
  // Outputs
  output logic      cpu_reset_n,
  output logic      wdt_expired
);

  wrc_state_t       state_q,  state_d;
  logic [CNT_W-1:0] hold_q,   hold_d;
  logic [CNT_W-1:0] wdt_q,    wdt_d;
  logic             exp_q,    exp_d;
  logic             svc_q,    svc_d;
  wrc_src_t         src;
  logic             any_req;

  function automatic logic [CNT_W-1:0] dec_sat(input logic [CNT_W-1:0] v);
    return (v == CNT_ZERO) ? CNT_ZERO : v - CNT_ONE;
  endfunction : dec_sat

  always_comb begin
    src.power_supervisor = ~power_supervisor_n;
    src.ext_reset        = ~ext_reset_n;
    src.watchdog_timer   = exp_q & ~wdt_disconnect;
  end

  assign any_req = |src;

  always_comb begin
    state_d = state_q;
    hold_d  = hold_q;
    wdt_d   = wdt_q;
    exp_d   = exp_q;
    svc_d   = wdt_service;
    unique case (state_q)
      WRC_RUN: begin
        if (any_req) begin
          state_d = WRC_HOLD;
          hold_d  = HOLD_CNT;
        end
      end
      WRC_HOLD: begin
        if (any_req) begin
          hold_d = HOLD_CNT;
        end else if (hold_q <= CNT_ONE) begin
          state_d = WRC_RUN;
          hold_d  = CNT_ZERO;
        end else begin
          hold_d = dec_sat(hold_q);
        end
      end
    endcase
    if (state_q == WRC_HOLD || any_req) begin
      wdt_d = CNT_ZERO;
      exp_d = 1'b0;
    end else if (wdt_service && !svc_q) begin
      wdt_d = CNT_ZERO;
    end else if (wdt_q >= WDT_CNT - CNT_ONE) begin
      exp_d = ~wdt_disconnect;
      wdt_d = CNT_ZERO;
    end else begin
      wdt_d = wdt_q + CNT_ONE;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_q <= WRC_HOLD;
      hold_q  <= CNT_ZERO;
      wdt_q   <= CNT_ZERO;
      exp_q   <= 1'b0;
      svc_q   <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      hold_q  <= hold_d;
      wdt_q   <= wdt_d;
      exp_q   <= exp_d;
      svc_q   <= svc_d;
    end
  end

  assign cpu_reset_n = (state_q == WRC_RUN);
  assign wdt_expired = exp_q;

  // Helper: cycles since reset output fell
  logic [CNT_W-1:0] low_cnt_q;
  always_ff @(posedge clock) begin
    if (!rstn || cpu_reset_n) begin
      low_cnt_q <= CNT_ZERO;
    end else if (clk_en && low_cnt_q != {CNT_W{1'b1}}) begin
      low_cnt_q <= low_cnt_q + CNT_ONE;
    end
  end

  property p_src_resets;
    @(posedge clock) disable iff (!rstn)
      (clk_en && any_req) |=> !cpu_reset_n;
  endproperty
  a_src_resets: assert property (p_src_resets) else $error("reset not asserted");

  property p_min_hold;
    @(posedge clock) disable iff (!rstn)
      ($rose(cpu_reset_n) && $past(low_cnt_q) != CNT_ZERO) |-> $past(low_cnt_q) >= HOLD_CNT - 1;
  endproperty
  a_min_hold: assert property (p_min_hold) else $error("reset released too early");

  property p_wdt_fires;
    @(posedge clock) disable iff (!rstn)
      (clk_en && cpu_reset_n && !any_req && !wdt_service && wdt_q >= WDT_CNT - CNT_ONE
       && !wdt_disconnect) |=> exp_q;
  endproperty
  a_wdt_fires: assert property (p_wdt_fires) else $error("watchdog did not expire");

  property p_disconnect;
    @(posedge clock) disable iff (!rstn)
      (clk_en && cpu_reset_n && power_supervisor_n && ext_reset_n && wdt_disconnect)
      |=> cpu_reset_n;
  endproperty
  a_disconnect: assert property (p_disconnect) else $error("reset while disconnected");

  property p_wdt_clear;
    @(posedge clock) disable iff (!rstn)
      (clk_en && !cpu_reset_n) |=> (wdt_q == CNT_ZERO && !exp_q);
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog ran during reset");

  property p_hold_restart;
    @(posedge clock) disable iff (!rstn)
      (clk_en && any_req && !cpu_reset_n) |=> hold_q == HOLD_CNT;
  endproperty
  a_hold_restart: assert property (p_hold_restart) else $error("hold not restarted");

  property p_ext_resets;
    @(posedge clock) disable iff (!rstn)
      (clk_en && !ext_reset_n) |=> !cpu_reset_n;
  endproperty
  a_ext_resets: assert property (p_ext_resets) else $error("external reset missed");

  property p_psu_resets;
    @(posedge clock) disable iff (!rstn)
      (clk_en && !power_supervisor_n) |=> !cpu_reset_n;
  endproperty
  a_psu_resets: assert property (p_psu_resets) else $error("supervisor reset missed");

  property p_exp_to_reset;
    @(posedge clock) disable iff (!rstn)
      (clk_en && exp_q && !wdt_disconnect) |=> !cpu_reset_n;
  endproperty
  a_exp_to_reset: assert property (p_exp_to_reset) else $error("expiry ignored");

  property p_exp_only_timeout;
    @(posedge clock) disable iff (!rstn)
      $rose(exp_q) |-> ($past(wdt_q) >= WDT_CNT - CNT_ONE && $past(clk_en));
  endproperty
  a_exp_only_timeout: assert property (p_exp_only_timeout) else $error("early expiry");

  property p_svc_restart;
    @(posedge clock) disable iff (!rstn)
      (clk_en && cpu_reset_n && !any_req && wdt_service && !svc_q)
      |=> wdt_q == CNT_ZERO;
  endproperty
  a_svc_restart: assert property (p_svc_restart) else $error("service ignored");

  property p_wdt_step;
    @(posedge clock) disable iff (!rstn)
      (clk_en && cpu_reset_n && !any_req && !(wdt_service && !svc_q)
       && wdt_q < WDT_CNT - CNT_ONE) |=> wdt_q == $past(wdt_q) + CNT_ONE;
  endproperty
  a_wdt_step: assert property (p_wdt_step) else $error("watchdog count skipped");

  property p_hold_count;
    @(posedge clock) disable iff (!rstn)
      (clk_en && !cpu_reset_n && !any_req && hold_q > CNT_ONE)
      |=> (!cpu_reset_n && hold_q == $past(hold_q) - CNT_ONE);
  endproperty
  a_hold_count: assert property (p_hold_count) else $error("hold count wrong");

  property p_release;
    @(posedge clock) disable iff (!rstn)
      (clk_en && !cpu_reset_n && !any_req && hold_q <= CNT_ONE) |=> cpu_reset_n;
  endproperty
  a_release: assert property (p_release) else $error("reset not released");

  property p_freeze;
    @(posedge clock) disable iff (!rstn)
      !clk_en |=> ($stable(state_q) && $stable(hold_q) && $stable(wdt_q) && $stable(exp_q));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

endmodule : wrc_top

// ==== tb/wrc_sw_model.sv ====
// Purpose: Software servicing the watchdog, and an external reset source.
// Assumes: Commands from the bench arrive at clock edges.
// Notes:   External reset pulse is kept at its minimum; service pulse is one cycle longer.
`timescale 1ns/1ps
module wrc_sw_model (
  // Clock
  input  wire logic clock,
  // Commands
  input  wire logic svc_on,
  input  wire logic ext_go,
  // Pins
  output logic      wdt_service = 1'b0,
  output logic      ext_reset_n = 1'b1
);
  int unsigned svc_cnt = 0;
  int unsigned ext_cnt = 0;
  always @(posedge clock) begin
    svc_cnt <= (svc_cnt == 29) ? 0 : svc_cnt + 1;
    wdt_service <= svc_on && (svc_cnt < 21);
    ext_cnt     <= ext_go ? 100 : ((ext_cnt != 0) ? ext_cnt - 1 : 0);
    ext_reset_n <= !(ext_go || ext_cnt > 1);
  end
endmodule : wrc_sw_model

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the watchdog and reset combiner.
// Assumes: Short hold and timeout counts.
// Notes:   Bench plays the supervisor and the strap itself.
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb_top
  import wrc_pkg::*;
;
  localparam int HOLD = 20;
  localparam int WDT  = 50;
  logic clock = 1'b0, rstn = 1'b0, psu_n = 1'b1, disc = 1'b0, svc_on = 1'b1, ext_go = 1'b0;
  logic wdt_service, ext_reset_n, cpu_reset_n, wdt_expired;
  logic en = 1'b1;
  int   fail_count = 0, n_tests = 0, n;
  wrc_top #(.HOLD_CNT(CNT_W'(HOLD)), .WDT_CNT(CNT_W'(WDT))) wrc_top_i (.clock(clock),
    .rstn(rstn), .clk_en(en), .power_supervisor_n(psu_n), .ext_reset_n(ext_reset_n),
    .wdt_service(wdt_service), .wdt_disconnect(disc), .cpu_reset_n(cpu_reset_n),
    .wdt_expired(wdt_expired));
  wrc_sw_model wrc_sw_model_i (.clock(clock), .svc_on(svc_on), .ext_go(ext_go),
    .wdt_service(wdt_service), .ext_reset_n(ext_reset_n));
  initial begin
    forever #2.5 clock = ~clock;
  end
  // Samples spent at one reset level, capped at 300
  task automatic span(input logic lvl);
    n = 0;
    if (clock === 1'b1) @(negedge clock);
    while (cpu_reset_n === lvl && n < 300) begin
      n++;
      @(negedge clock);
    end
  endtask : span
  task automatic t_serviced();
    span(1'b1);
    `CHK(n, 300)
    $display("serviced done");
  endtask : t_serviced
  task automatic t_ext();
    @(posedge clock) ext_go <= 1'b1;
    @(posedge clock) ext_go <= 1'b0;
    span(1'b1);
    `CHK(n < 5, 1'b1)
    span(1'b0);
    `CHK(n >= 99 + HOLD, 1'b1)
    $display("ext reset done");
  endtask : t_ext
  task automatic t_disc();
    @(posedge clock) begin
      disc   <= 1'b1;
      svc_on <= 1'b0;
    end
    span(1'b1);
    `CHK(n, 300)
    `CHK(wdt_expired, 1'b0)
    $display("disconnect done");
  endtask : t_disc
  task automatic t_psu();
    @(posedge clock) begin
      psu_n <= 1'b0;
      disc  <= 1'b0;
    end
    repeat (5) @(negedge clock);
    `CHK(cpu_reset_n, 1'b0)
    @(posedge clock) psu_n <= 1'b1;
    span(1'b0);
    `CHK(n >= HOLD, 1'b1)
    $display("supervisor done");
  endtask : t_psu
  task automatic t_wdt();
    span(1'b1);
    `CHK(n >= WDT && n <= WDT + 3, 1'b1)
    span(1'b0);
    `CHK(n >= HOLD, 1'b1)
    $display("watchdog done");
  endtask : t_wdt
  task automatic t_freeze();
    @(posedge clock) en <= 1'b0;
    span(1'b1);
    `CHK(n, 300)
    `CHK(wdt_expired, 1'b0)
    @(posedge clock) en <= 1'b1;
    $display("freeze done");
  endtask : t_freeze
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    span(1'b0);
    t_serviced();
    t_ext();
    t_disc();
    t_psu();
    t_wdt();
    t_freeze();
    wrap_up();
  end
  initial begin
    #20000;
    fail_count++;
    wrap_up();
  end
endmodule : tb_top
